/* design/cps_pkg.sv */
// package for the chassis power-on sequencer: timing constants, carriers, states
// assumes a 25 MHz system clock and synchronous active-high reset
package cps_pkg;

	localparam int CLK_HZ = 25000000;
	localparam int RAIL_COUNT = 4;

	// gaps between successive rail enables, in milliseconds as specified
	localparam int GAP1_MS = 1;
	localparam int GAP2_MS = 3;
	localparam int GAP3_MS = 1;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int GAP1_CYC = GAP1_MS * CYC_PER_MS;
	localparam int GAP2_CYC = GAP2_MS * CYC_PER_MS;
	localparam int GAP3_CYC = GAP3_MS * CYC_PER_MS;

	localparam int SYNC_STAGES = 3;
	localparam logic [3:0] RAILS_OFF = 4'h0;

	// raw inputs grouped as they arrive from the chassis
	typedef struct packed {
		logic request_source_select;
		logic slot_power_request;
		logic external_power_request;
		logic power_fail;
		logic rail_12v_ok;
		logic rail_5v_ok;
		logic rail_3v3_ok;
	} cps_inputs_s;

	localparam int IN_W = $bits(cps_inputs_s);

	typedef enum logic [2:0] {
		CPS_OFF,
		CPS_GAP1,
		CPS_GAP2,
		CPS_GAP3,
		CPS_ON
	} cps_state_e;

endpackage : cps_pkg

/* design/cps_sync.sv */
// three-stage input synchroniser with agreement filter for a vector of pins
// assumes every bit is asynchronous to clock_i
`timescale 1ns/10ps
module cps_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] sync_next;

	// the output only moves once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign sync_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : sync_o[g];
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_o <= '0;
		end else begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sync_o <= sync_next;
		end
	end
endmodule : cps_sync

/* design/cps_sequencer.sv */
// chassis power-on sequencer: picks a request source, ramps four rail enables, reports good
// assumes all inputs are asynchronous pins; outputs drive supply enables directly
`timescale 1ns/10ps
module cps_sequencer #(
	parameter int GAP1_CYCLES = cps_pkg::GAP1_CYC,
	parameter int GAP2_CYCLES = cps_pkg::GAP2_CYC,
	parameter int GAP3_CYCLES = cps_pkg::GAP3_CYC
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire cps_pkg::cps_inputs_s pins_i,
	output logic [cps_pkg::RAIL_COUNT-1:0] rail_enable_out_o,
	output logic rails_good_o,
	output logic sequence_done_o
);
	import cps_pkg::*;

	localparam int CNT_W = 18;

	cps_inputs_s sync_in;
	cps_state_e state_reg;
	cps_state_e state_next;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [RAIL_COUNT-1:0] rail_next;
	logic selected_request;
	logic run_ok;
	logic gap_done;
	logic good_next;

	// rail pattern that belongs to each stage; one table keeps the ramp steps and the hold in step
	function automatic logic [RAIL_COUNT-1:0] stage_rails(input cps_state_e st);
		logic [RAIL_COUNT-1:0] pat;
		pat = RAILS_OFF;
		case (st)
			CPS_GAP1: begin
				pat = 4'h1;
			end
			CPS_GAP2: begin
				pat = 4'h3;
			end
			CPS_GAP3: begin
				pat = 4'h7;
			end
			CPS_ON: begin
				pat = 4'hf;
			end
			default: begin
				pat = RAILS_OFF;
			end
		endcase
		return pat;
	endfunction : stage_rails

	cps_sync #(
		.WIDTH(IN_W)
	) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.async_i(pins_i),
		.sync_o(sync_in)
	);

	// source mux: are the two arms of it
	assign selected_request = sync_in.request_source_select ?
		sync_in.slot_power_request : sync_in.external_power_request;
	// a power fail is treated like a withdrawn request
	assign run_ok = selected_request && !sync_in.power_fail;
	assign gap_done = (count_reg == '0);
	assign good_next = sync_in.rail_12v_ok && sync_in.rail_5v_ok
		&& sync_in.rail_3v3_ok;

	always_comb begin
		state_next = state_reg;
		count_next = gap_done ? count_reg : count_reg - 1'b1;
		rail_next = rail_enable_out_o;
		if (!run_ok) begin
			// abort anywhere, even mid-ramp, so no rail is left half sequenced
			state_next = CPS_OFF;
			rail_next = RAILS_OFF;
			count_next = '0;
		end else begin
			case (state_reg)
				CPS_OFF: begin
					state_next = CPS_GAP1;
					rail_next = stage_rails(CPS_GAP1);
					count_next = CNT_W'(GAP1_CYCLES - 1);
				end
				CPS_GAP1: begin
					if (gap_done) begin
						state_next = CPS_GAP2;
						rail_next = stage_rails(CPS_GAP2);
						count_next = CNT_W'(GAP2_CYCLES - 1);
					end
				end
				CPS_GAP2: begin
					if (gap_done) begin
						state_next = CPS_GAP3;
						rail_next = stage_rails(CPS_GAP3);
						count_next = CNT_W'(GAP3_CYCLES - 1);
					end
				end
				CPS_GAP3: begin
					if (gap_done) begin
						state_next = CPS_ON;
						rail_next = stage_rails(CPS_ON);
					end
				end
				CPS_ON: begin
					// hold the full pattern; only a drop or a fail leaves this stage
					rail_next = stage_rails(CPS_ON);
				end
				default: begin
					state_next = CPS_OFF;
					rail_next = RAILS_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_reg <= CPS_OFF;
			count_reg <= '0;
			rail_enable_out_o <= RAILS_OFF;
			rails_good_o <= 1'b0;
			sequence_done_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			rail_enable_out_o <= rail_next;
			rails_good_o <= good_next;
			sequence_done_o <= (state_next == CPS_ON);
		end
	end
endmodule : cps_sequencer

/* verif/cps_monitor.sv */
// checker on the cps_sequencer ports
// assumes the four-edge input synchroniser of the design
`timescale 1ns/10ps
module cps_monitor #(
	parameter int GAP1_CYCLES = 4,
	parameter int GAP2_CYCLES = 12,
	parameter int GAP3_CYCLES = 4
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire cps_pkg::cps_inputs_s pins_i,
	input wire logic [3:0] rail_enable_out_o,
	input wire logic rails_good_o,
	input wire logic sequence_done_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire logic [3:0] r = rail_enable_out_o;
	wire logic req = pins_i.request_source_select ? pins_i.slot_power_request
		: pins_i.external_power_request;
	wire logic go = req && !pins_i.power_fail;
	wire logic ok = pins_i.rail_12v_ok && pins_i.rail_5v_ok && pins_i.rail_3v3_ok;
	sequence s_go; go [*7]; endsequence
	sequence s_stop; !go [*7]; endsequence
	order_legal_a: assert property (r inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
		else $error("rail enables out of order");
	start_req_a: assert property (s_go |-> r[0])
		else $error("ramp not started");
	gap_one_a: assert property ($rose(r[0]) ##GAP1_CYCLES r[0] |-> $rose(r[1]))
		else $error("second rail gap wrong");
	gap_two_a: assert property ($rose(r[1]) ##GAP2_CYCLES r[1] |-> $rose(r[2]))
		else $error("third rail gap wrong");
	gap_three_a: assert property ($rose(r[2]) ##GAP3_CYCLES r[2] |-> $rose(r[3]))
		else $error("fourth rail gap wrong");
	done_full_a: assert property (sequence_done_o == (r == 4'hf))
		else $error("done flag wrong");
	stop_all_a: assert property (s_stop |-> r == 4'h0)
		else $error("rails not shut down");
	good_high_a: assert property (ok [*7] |-> rails_good_o)
		else $error("good flag missing");
	good_low_a: assert property (!ok [*7] |-> !rails_good_o)
		else $error("good flag stuck");
endmodule : cps_monitor
bind cps_sequencer cps_monitor #(.GAP1_CYCLES(GAP1_CYCLES), .GAP2_CYCLES(GAP2_CYCLES),
	.GAP3_CYCLES(GAP3_CYCLES)) u_cps_monitor (.*);

/* verif/cps_psu_model.sv */
// rail monitor model: a rail reads good one cycle after its enable
// assumes drop_i forces every rail under threshold
`timescale 1ns/10ps
module cps_psu_model (
	input wire logic clock_i,
	input wire logic [3:0] en_i,
	input wire logic drop_i,
	output logic [2:0] ok_o
);
	always_ff @(posedge clock_i) begin
		ok_o <= drop_i ? 3'h0 : {en_i[1], en_i[0], en_i[2]};
	end
endmodule : cps_psu_model

/* verif/cps_sequencer_tb_top.sv */
// bench for cps_sequencer: ramps from both sources, aborts, fail, good flag
// assumes short gaps of 4, 12 and 4 cycles
`timescale 1ns/10ps
module cps_sequencer_tb_top;
	import cps_pkg::*;
	logic clock_i = 0;
	logic sys_rst_i = 1;
	logic sel = 1, slot = 0, ext = 0, pf = 0, drop = 0;
	logic [2:0] ok;
	logic [3:0] rail;
	logic good, done;
	int n_mismatch = 0, samples_checked = 0, n;
	cps_inputs_s pins;
	// reference ramp written from the rules: each step's pattern and its gap in cycles
	logic [3:0] step_q[$] = '{4'h1, 4'h3, 4'h7, 4'hf};
	int gap_q[$] = '{4, 12, 4};
	assign pins = '{sel, slot, ext, pf, ok[2], ok[1], ok[0]};
	always #20 clock_i = ~clock_i;
	cps_sequencer #(.GAP1_CYCLES(4), .GAP2_CYCLES(12), .GAP3_CYCLES(4)) u_cps_sequencer (
		.clock_i, .sys_rst_i, .pins_i(pins), .rail_enable_out_o(rail),
		.rails_good_o(good), .sequence_done_o(done));
	cps_psu_model u_cps_psu_model (.clock_i, .en_i(rail), .drop_i(drop), .ok_o(ok));
	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	// counts falling edges until the enables show v
	task automatic wait_rail(input logic [3:0] v);
		n = 0;
		while (rail !== v) begin
			@(negedge clock_i);
			n++;
			if (n > 99) begin
				n_mismatch++;
				results();
			end
		end
	endtask : wait_rail
	task automatic ramp(input logic s);
		sel = s;
		// the source not selected gets a random level; the mux must ignore it
		slot = s ? 1'b1 : 1'($urandom);
		ext = s ? 1'($urandom) : 1'b1;
		wait_rail(step_q[0]);
		chk("start", 32'(n <= 6), 1);
		wait_rail(step_q[1]);
		chk("gap1", n, gap_q[0]);
		wait_rail(step_q[2]);
		chk("gap2", n, gap_q[1]);
		wait_rail(step_q[3]);
		chk("gap3", n, gap_q[2]);
		chk("done", 32'(done), 1);
		repeat (8) @(negedge clock_i);
		chk("good", 32'(good), 32'(ok == 3'h7));
	endtask : ramp
	initial begin
		void'($urandom(32'hb022));
		repeat (5) @(negedge clock_i);
		sys_rst_i = 0;
		ramp(1);
		drop = 1;
		repeat (8) @(negedge clock_i);
		chk("bad", 32'(good), 0);
		chk("rail", 32'(rail), 32'hf);
		drop = 0;
		ext = 0;
		sel = 0;
		wait_rail(4'h0);
		chk("sel", 32'(n <= 7), 1);
		ramp(0);
		pf = 1;
		wait_rail(4'h0);
		chk("fail", 32'(n <= 7), 1);
		pf = 0;
		wait_rail(4'h1);
		repeat ($urandom_range(1, 20)) @(negedge clock_i);
		ext = 0;
		wait_rail(4'h0);
		chk("abort", 32'(n <= 7), 1);
		results();
	end
endmodule : cps_sequencer_tb_top
